// [pkg/eerd_defs.vh]
// constants for the serial eeprom read and acknowledge-poll slave
`ifndef EERD_DEFS_VH
`define EERD_DEFS_VH
`define EERD_ADDR_W 13
`define EERD_ADDR_TOP 13'h1FFF
`define EERD_ADDR_BOTTOM 13'h0000
`define EERD_RW_BIT 0
`define EERD_SEL_LSB 1
`define EERD_TYPE_LSB 4
`define EERD_WRITE_TIME_NS 5000000
`define EERD_CLK_PERIOD_NS 4
`define EERD_WRITE_CYCLES (`EERD_WRITE_TIME_NS / `EERD_CLK_PERIOD_NS)
`define EERD_FIFO_W 8
`define EERD_FIFO_D 16
`endif

// [hw/eerd_sync.v]
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module eerd_sync (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// pin side
	input wire pin_in,
	// filtered level
	output reg level
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge core_clk) begin
		if (!nrst) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level <= 1'b1;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// [hw/eerd_fifo.v]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module eerd_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	always @(posedge core_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always @(posedge core_clk) begin
		if (!nrst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [hw/eerd_slave.v]
// two-wire eeprom slave: acknowledge polling and current, random and sequential reads
// Summary of operation
// RULE_01: no control byte acknowledge while writing
// RULE_02: write cycle starts at stop after write
// RULE_03: master polls with write-type control byte
// RULE_04: master repeats start and control until ack
// RULE_05: ack polling byte once cycle finished
// RULE_06: reads start like writes, read bit one
// RULE_07: counter holds last address plus one
// RULE_08: ack read control, send byte at counter
// RULE_09: no ack then stop ends read, release
// RULE_10: random read loads address via write command
// RULE_11: repeated start after address keeps pointer, no write
// RULE_12: read control after restart sends loaded byte
// RULE_13: after random read counter points past byte
// RULE_14: master ack makes device send next byte
// RULE_15: master ends sequential read with nack, stop
// RULE_16: pointer increments after every byte transferred
// RULE_17: pointer wraps from 1FFF to 0000
// RULE_18: control byte matches type and select pins
// RULE_19: two address bytes, high first, 13 bits used
// RULE_20: release data line after master nack
// RULE_21: busy cycle ignores reads too
`timescale 1ns/1ns
`default_nettype none
`include "eerd_defs.vh"
module eerd_slave #(
	parameter [3:0] DEVICE_TYPE = 4'h5,
	parameter WRITE_CYCLES = `EERD_WRITE_CYCLES
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// serial bus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// chip select straps
	input wire chip_select_bit_two,
	input wire chip_select_bit_one,
	input wire chip_select_bit_zero,
	// memory array read port
	output reg [12:0] mem_addr,
	input wire [7:0] mem_rdata,
	// received write data stream
	output reg wr_valid,
	input wire wr_ready,
	output reg [7:0] wr_data,
	output reg [12:0] wr_addr,
	// status
	output reg write_busy
);
	// ==========================================
	// states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CTRL = 3'h1;
	localparam [2:0] ST_ADDR_HI = 3'h2;
	localparam [2:0] ST_ADDR_LO = 3'h3;
	localparam [2:0] ST_WDATA = 3'h4;
	localparam [2:0] ST_RDATA = 3'h5;
	localparam [2:0] ST_RACK = 3'h6;
	localparam [2:0] ST_WAIT = 3'h7;

	// ==========================================
	// pin synchronisers
	wire scl;
	wire sda;
	eerd_sync u_sync_scl (
		.core_clk(core_clk),
		.nrst(nrst),
		.pin_in(scl_in),
		.level(scl)
	);
	eerd_sync u_sync_sda (
		.core_clk(core_clk),
		.nrst(nrst),
		.pin_in(sda_in),
		.level(sda)
	);
	reg scl_d;
	reg sda_d;
	wire scl_rise = scl && !scl_d;
	wire scl_fall = !scl && scl_d;
	wire start_cond = scl && scl_d && sda_d && !sda;
	wire stop_cond = scl && scl_d && !sda_d && sda;

	// ==========================================
	// write data buffer
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	reg fifo_push;
	reg [7:0] fifo_push_data;
	reg commit;
	reg discard;
	eerd_fifo #(
		.WIDTH(`EERD_FIFO_W),
		.DEPTH(`EERD_FIFO_D),
		.AW(4)
	) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_push_data),
		.out_valid(fifo_out_valid),
		.out_ready((commit && (!wr_valid || wr_ready)) || discard),
		.out_data(fifo_out_data)
	);

	// ==========================================
	// control byte match
	function match_ctrl;
		input [7:0] b;
		input [2:0] sel;
		begin
			match_ctrl = (b[7:`EERD_TYPE_LSB] == DEVICE_TYPE) && // see RULE_18
				(b[`EERD_TYPE_LSB-1:`EERD_SEL_LSB] == sel);
		end
	endfunction

	// ==========================================
	// main state
	reg [2:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg ack_phase;
	reg [12:0] addr_ptr;
	reg [12:0] wr_ptr;
	reg [4:0] addr_hi;
	reg got_data;
	reg [31:0] busy_cnt;
	wire [2:0] sel_pins = {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero};
	wire [7:0] rx_byte = {shreg[6:0], sda};

	always @(posedge core_clk) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ack_phase <= 1'b0;
			addr_ptr <= `EERD_ADDR_BOTTOM;
			wr_ptr <= `EERD_ADDR_BOTTOM;
			addr_hi <= 5'h00;
			got_data <= 1'b0;
			busy_cnt <= 32'h0;
			write_busy <= 1'b0;
			commit <= 1'b0;
			discard <= 1'b0;
			fifo_push <= 1'b0;
			fifo_push_data <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			mem_addr <= `EERD_ADDR_BOTTOM;
			wr_valid <= 1'b0;
			wr_data <= 8'h00;
			wr_addr <= `EERD_ADDR_BOTTOM;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			fifo_push <= 1'b0;
			mem_addr <= addr_ptr;
			if (discard && !fifo_out_valid) begin
				discard <= 1'b0;
			end
			// drain buffered bytes into the array during the busy cycle
			if (wr_valid && wr_ready) begin
				wr_valid <= 1'b0;
			end
			if (commit && fifo_out_valid && (!wr_valid || wr_ready)) begin
				wr_valid <= 1'b1;
				wr_data <= fifo_out_data;
				wr_addr <= wr_ptr;
				wr_ptr <= {wr_ptr[12:5], wr_ptr[4:0] + 5'h01};
			end
			if (write_busy) begin
				if (busy_cnt != 32'h0) begin
					busy_cnt <= busy_cnt - 32'h1;
				end else if (!fifo_out_valid && !wr_valid) begin
					write_busy <= 1'b0; // see RULE_05
					commit <= 1'b0;
				end
			end
			if (start_cond) begin
				state <= ST_CTRL; // see RULE_11
				bit_cnt <= 4'h0;
				ack_phase <= 1'b0;
				sda_oe <= 1'b0;
				if (got_data) begin
					got_data <= 1'b0;
					discard <= 1'b1; // drop bytes of a cut write, see RULE_11
				end
			end else if (stop_cond) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0; // see RULE_09
				if (got_data && !write_busy) begin
					write_busy <= 1'b1; // see RULE_02
					commit <= 1'b1;
					busy_cnt <= WRITE_CYCLES[31:0];
				end
				got_data <= 1'b0;
			end else if (state != ST_IDLE && state != ST_WAIT) begin
				if (scl_rise && !ack_phase && state != ST_RDATA) begin
					shreg <= rx_byte;
					bit_cnt <= bit_cnt + 4'h1;
				end
				if (scl_rise && ack_phase && state == ST_RACK) begin
					if (sda) begin
						state <= ST_WAIT; // see RULE_20
					end else begin
						state <= ST_RDATA; // see RULE_14
					end
				end
				if (scl_fall) begin
					if (ack_phase) begin
						ack_phase <= 1'b0;
						bit_cnt <= 4'h0;
						sda_oe <= 1'b0;
						if (state == ST_RDATA) begin
							sda_oe <= 1'b1;
							sda_out <= mem_rdata[7]; // see RULE_08
							shreg <= {mem_rdata[6:0], 1'b1};
							bit_cnt <= 4'h1;
							addr_ptr <= addr_ptr + 13'h0001; // see RULE_16
						end
					end else if (state == ST_RDATA && bit_cnt != 4'h8) begin
						sda_out <= shreg[7];
						shreg <= {shreg[6:0], 1'b1};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (state == ST_RDATA) begin
						sda_oe <= 1'b0;
						ack_phase <= 1'b1;
						state <= ST_RACK;
					end else if (bit_cnt == 4'h8) begin
						ack_phase <= 1'b1;
						case (state)
							ST_CTRL: begin
								if (write_busy || !match_ctrl(shreg, sel_pins)) begin
									state <= ST_WAIT; // see RULE_01 RULE_21
								end else if (shreg[`EERD_RW_BIT]) begin
									sda_oe <= 1'b1; // see RULE_12
									sda_out <= 1'b0;
									state <= ST_RDATA;
								end else begin
									sda_oe <= 1'b1; // see RULE_05
									sda_out <= 1'b0;
									state <= ST_ADDR_HI;
								end
							end
							ST_ADDR_HI: begin
								addr_hi <= shreg[4:0]; // see RULE_19
								sda_oe <= 1'b1;
								sda_out <= 1'b0;
								state <= ST_ADDR_LO;
							end
							ST_ADDR_LO: begin
								addr_ptr <= {addr_hi, shreg}; // see RULE_07
								wr_ptr <= {addr_hi, shreg};
								sda_oe <= 1'b1;
								sda_out <= 1'b0;
								state <= ST_WDATA;
							end
							ST_WDATA: begin
								if (fifo_in_ready) begin
									fifo_push <= 1'b1;
									fifo_push_data <= shreg;
									got_data <= 1'b1;
									addr_ptr <= {addr_ptr[12:5], addr_ptr[4:0] + 5'h01};
									sda_oe <= 1'b1;
									sda_out <= 1'b0;
								end
							end
							default: begin
								state <= ST_WAIT;
							end
						endcase
					end
				end
			end
			// the pointer is explicitly loaded back from 1FFF to 0000 on read, see RULE_17
			if (state == ST_RDATA && ack_phase && scl_fall && addr_ptr == `EERD_ADDR_TOP) begin
				addr_ptr <= `EERD_ADDR_BOTTOM; // see RULE_13
			end
		end
	end
endmodule
`default_nettype wire

// [tb/eerd_chk.sv]
// assertion checker for the eeprom read slave
`timescale 1ns/1ns
`default_nettype none
module eerd_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// array and stream
	input wire logic [12:0] mem_addr,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [7:0] wr_data,
	input wire logic write_busy
);
	// ========
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_busy_mute: assert property (write_busy |-> !sda_oe)
		else $error("drive while busy");
	a_busy_len: assert property ($rose(write_busy) |-> write_busy [*8])
		else $error("busy too short");
	a_busy_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
		else $error("busy not at stop");
	a_reset_quiet: assert property (disable iff (1'b0) !nrst |=>
		!sda_oe && !write_busy && !wr_valid && mem_addr == 13'h0000)
		else $error("reset state wrong");
	a_drive_low: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("drive in high phase");
	a_release_low: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("release in high phase");
	a_hold_high: assert property (scl_in && $past(scl_in) |->
		$stable(sda_oe) && (!sda_oe || $stable(sda_out)))
		else $error("data moved in high phase");
	a_stream_hold: assert property (wr_valid && !wr_ready |=>
		wr_valid && $stable(wr_data))
		else $error("stream dropped");
	c_write: cover property ($fell(write_busy));
	c_release: cover property ($fell(sda_oe));
	c_stall: cover property (wr_valid && !wr_ready);
endmodule
bind eerd_slave eerd_chk i_chk (.*);
`default_nettype wire

// [tb/eerd_master.sv]
// two-wire bus master model driving clock and commands
`timescale 1ns/1ns
`default_nettype none
module eerd_master (
	// clock
	input wire logic core_clk,
	// bus wires
	input wire logic sda_w,
	output var logic scl,
	output var logic m_sda
);
	// ========
	// bus cycles
	initial begin
		scl = 1'b1;
		m_sda = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// data changes only in the low phase
	task automatic bitx(input logic b, output logic r);
		scl = 1'b0;
		w(5);
		m_sda = b;
		w(6);
		scl = 1'b1;
		w(4);
		r = sda_w;
		w(1);
	endtask
	// start is cond(1,0), stop is cond(0,1)
	task automatic cond(input logic a, input logic z);
		scl = 1'b0;
		w(6);
		m_sda = a;
		w(6);
		scl = 1'b1;
		w(12);
		m_sda = z;
		w(12);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// nack on the last byte ends a read
	task automatic recv(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, r);
			d = {d[6:0], r};
		end
		bitx(!ack, r);
	endtask
endmodule
`default_nettype wire

// [tb/eeprom_read_and_ack_poll_tb_top.sv]
// testbench for the eeprom read and acknowledge-poll slave
`timescale 1ns/1ns
`default_nettype none
module eeprom_read_and_ack_poll_tb_top;
	localparam logic [3:0] TYP = 4'h6; // arbitrary device type code
	localparam logic [2:0] SEL = 3'h5;
	logic core_clk, nrst, scl, m_sda, sda_out, sda_oe, wr_valid, wr_ready, write_busy;
	logic ack;
	logic [12:0] mem_addr, wr_addr;
	logic [7:0] mem_rdata, wr_data, d;
	logic [7:0] mem [0:8191];
	logic [2:0] pins;
	int n_fail, compares, cyc;
	wire sda_w = m_sda & (!sda_oe | sda_out);
	assign mem_rdata = mem[mem_addr];
	eerd_slave #(.DEVICE_TYPE(TYP), .WRITE_CYCLES(2000)) i_dut (
		.core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_bit_two(pins[2]), .chip_select_bit_one(pins[1]),
		.chip_select_bit_zero(pins[0]), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_addr(wr_addr),
		.write_busy(write_busy));
	// array model: takes the write stream, stalling one cycle in three
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) begin
			mem[wr_addr] <= wr_data;
		end
	end
	always @(posedge core_clk) begin
		#1;
		wr_ready = (cyc % 3) != 2;
	end
	eerd_master i_m (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .m_sda(m_sda));
	// ========
	// helpers
	function automatic logic [7:0] ex(input logic [12:0] a);
		return a[7:0] ^ {3'h0, a[12:8]};
	endfunction
	function automatic logic [7:0] cb(input logic [2:0] s, input logic rw);
		return {TYP, s, rw};
	endfunction
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ========
	// scenarios
	task automatic t_select;
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(3'h4, 1'b0), ack);
		chk("ack bad select", 0, ack);
		i_m.cond(1'b1, 1'b0);
		i_m.send({4'h9, SEL, 1'b0}, ack);
		chk("ack bad type", 0, ack);
		i_m.cond(1'b0, 1'b1);
		pins = 3'h2;
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b0), ack);
		chk("ack old select", 0, ack);
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(3'h2, 1'b0), ack);
		chk("ack new select", 1, ack);
		i_m.cond(1'b0, 1'b1);
		pins = SEL;
	endtask
	task automatic t_write_poll;
		int i;
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b0), ack);
		chk("ack write", 1, ack);
		i_m.send(8'hFF, ack);
		i_m.send(8'hE0, ack);
		for (i = 0; i < 16; i++) i_m.send(8'h30 + i[7:0], ack);
		i_m.cond(1'b0, 1'b1);
		chk("busy", 1, write_busy);
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b1), ack);
		chk("ack read busy", 0, ack);
		i = 0;
		do begin
			i_m.cond(1'b1, 1'b0);
			i_m.send(cb(SEL, 1'b0), ack);
			i++;
		end while (!ack && i < 40);
		chk("poll ack", 1, ack);
		chk("busy done", 0, write_busy);
		chk("poll refused", 1, i > 1);
		for (i = 0; i < 16; i++) chk("array data", 8'h30 + i[7:0], mem[13'h1FE0 + i]);
		i_m.send(8'hFF, ack);
		i_m.send(8'hE0, ack);
		chk("ack addr lo", 1, ack);
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b1), ack);
		chk("ack reread", 1, ack);
		i_m.recv(1'b0, d);
		chk("data written", 8'h30, d);
		i_m.cond(1'b0, 1'b1);
		chk("page tail kept", ex(13'h1FF0), mem[13'h1FF0]);
	endtask
	task automatic t_read;
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b0), ack);
		i_m.send(8'hFF, ack);
		i_m.send(8'hFF, ack);
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b1), ack);
		chk("ack read", 1, ack);
		i_m.recv(1'b1, d);
		chk("data top", ex(13'h1FFF), d);
		i_m.recv(1'b1, d);
		chk("data wrap", ex(13'h0000), d);
		i_m.recv(1'b0, d);
		chk("data next", ex(13'h0001), d);
		i_m.cond(1'b0, 1'b1);
		chk("released", 0, sda_oe);
		i_m.cond(1'b1, 1'b0);
		i_m.send(cb(SEL, 1'b1), ack);
		i_m.recv(1'b0, d);
		chk("data current", ex(13'h0002), d);
		i_m.cond(1'b0, 1'b1);
	endtask
	// ========
	// clock, timeout and sequence
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		nrst = 1'b0;
		pins = SEL;
		for (int a = 0; a < 8192; a++) mem[a] = ex(a[12:0]);
		repeat (2) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		i_m.w(10);
		chk("idle oe", 0, sda_oe);
		chk("idle busy", 0, write_busy);
		t_select();
		t_write_poll();
		t_read();
		wrap_up();
	end
endmodule
`default_nettype wire
